//--- verilog/ccg_ctrl.sv
`timescale 1ns/10ps
`include "ccg_map.svh"
module ccg_ctrl
(
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic reset_i,
	// Serial bus, open drain data
	input wire logic scl_i,
	input wire logic sda_i,
	output wire logic sda_o,
	output wire logic sda_oe_o,
	// Device pins
	input wire logic [2:0] config_select_i,
	input wire logic source_switch_pin_i,
	input wire logic shutdown_oe_pin_i,
	input wire logic prim_lost_i,
	// Reference selection
	output logic osc_bypass_sel_o,
	output logic ref_sel_o,
	output logic on_secondary_o,
	output logic cfg_invalid_o,
	// Output control
	output logic global_shutdown_o,
	output logic [`CCG_NOUT-1:0] out_enable_o,
	output logic [`CCG_NOUT-1:0] out_hiz_o,
	output logic [`CCG_NOUT-1:0] out_suspend_o,
	// Status
	output wire logic nv_busy_o
);
	ccg_nv_if nv ();

	ccg_nvmem u_nvmem
	(
		.sys_clk_i(sys_clk_i),
		.reset_i(reset_i),
		.nv(nv)
	);

	// Pin synchronisers: meta stage, sync stage, delayed copy
	logic [7:0] pin_meta_r;
	logic [7:0] pin_sync_r;
	logic [1:0] bus_dly_r;
	wire [7:0] pins = {prim_lost_i, config_select_i, shutdown_oe_pin_i,
		source_switch_pin_i, sda_i, scl_i};

	always_ff @(posedge sys_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			pin_meta_r <= 8'hFF;
			pin_sync_r <= 8'hFF;
			bus_dly_r <= 2'h3;
		end
		else
		begin
			pin_meta_r <= pins;
			pin_sync_r <= pin_meta_r;
			bus_dly_r <= pin_sync_r[1:0];
		end
	end

	wire scl_s = pin_sync_r[0];
	wire sda_s = pin_sync_r[1];
	wire sw_s = pin_sync_r[2];
	wire sd_s = pin_sync_r[3];
	wire [2:0] sel_s = pin_sync_r[6:4];
	wire lost_s = pin_sync_r[7];
	wire rise = scl_s && !bus_dly_r[0];
	wire fall = !scl_s && bus_dly_r[0];
	// Data edges while the clock stays high frame the transfer
	wire start_det = scl_s && bus_dly_r[0] && !sda_s && bus_dly_r[1];
	wire stop_det = scl_s && bus_dly_r[0] && sda_s && !bus_dly_r[1];

	// Serial engine state
	ccg_pkg::ccg_i2c_st_t state_r;
	logic [3:0] bit_cnt_r;	// Bits of current byte
	logic [7:0] rx_sr_r;	// Received byte
	logic [7:0] tx_sr_r;	// Byte being sent
	logic [1:0] phase_r;	// Byte position in frame
	logic rw_r;	// Read direction
	logic [1:0] cmd_r;	// Command code
	logic [7:0] idx_r;	// Register index
	logic ack_drv_r;	// Pull data low in ack slot
	logic mack_r;	// Master acknowledged
	logic id_r;	// Byte in flight is the identity
	logic nv_start_r;
	logic nv_restore_r;
	logic [7:0] regs_r [`CCG_NREG];	// Programming registers

	// Byte decisions
	wire rx_done = (state_r == ccg_pkg::ST_RX) && fall
		&& (bit_cnt_r == `CCG_BIT_LAST);
	// Busy copy hides the device from the bus
	wire addr_hit = (rx_sr_r[7:1] == `CCG_SLAVE_ADDR) && !nv.busy;
	// Only a write command takes index and data bytes
	wire ack_ok = (phase_r == `CCG_PH_ADDR) ? addr_hit :
		(phase_r == `CCG_PH_CMD) ? 1'b1 : (cmd_r == `CCG_CMD_WRITE);
	wire wr_byte = rx_done && ack_ok && (phase_r == `CCG_PH_DATA);
	// Dataless two-byte frame with save or restore code
	wire nv_req = stop_det && (phase_r == `CCG_PH_INDEX) && !rw_r
		&& (cmd_r == `CCG_CMD_SAVE || cmd_r == `CCG_CMD_RESTORE);

	// Frame sequencing; start and stop override any state
	always_ff @(posedge sys_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			state_r <= ccg_pkg::ST_IDLE;
			bit_cnt_r <= 4'h0;
			rx_sr_r <= 8'h00;
			tx_sr_r <= 8'h00;
			phase_r <= `CCG_PH_ADDR;
			rw_r <= 1'b0;
			cmd_r <= `CCG_CMD_WRITE;
			idx_r <= 8'h00;
			ack_drv_r <= 1'b0;
			mack_r <= 1'b0;
			id_r <= 1'b0;
		end
		else if (start_det)
		begin
			// Repeated start keeps the index for reads
			state_r <= ccg_pkg::ST_RX;
			bit_cnt_r <= 4'h0;
			phase_r <= `CCG_PH_ADDR;
			ack_drv_r <= 1'b0;
		end
		else if (stop_det)
		begin
			state_r <= ccg_pkg::ST_IDLE;
			ack_drv_r <= 1'b0;
		end
		else
		begin
			case (state_r)
				ccg_pkg::ST_RX:
				begin
					if (rise)
					begin
						rx_sr_r <= {rx_sr_r[6:0], sda_s};
						bit_cnt_r <= bit_cnt_r + 4'h1;
					end
					else if (rx_done)
					begin
						bit_cnt_r <= 4'h0;
						ack_drv_r <= ack_ok;
						state_r <= ack_ok ? ccg_pkg::ST_ACK
							: ccg_pkg::ST_SKIP;
						if (ack_ok && phase_r != `CCG_PH_DATA)
							phase_r <= phase_r + 2'h1;
						if (phase_r == `CCG_PH_ADDR)
							rw_r <= rx_sr_r[0];
						if (phase_r == `CCG_PH_CMD)
							cmd_r <= rx_sr_r[1:0];
						// Index byte loads, data bytes step it
						if (ack_ok && phase_r == `CCG_PH_INDEX)
							idx_r <= rx_sr_r;
						if (wr_byte)
							idx_r <= idx_r + 8'h01;
					end
				end
				ccg_pkg::ST_ACK:
				begin
					if (fall)
					begin
						ack_drv_r <= 1'b0;
						// Read opens with the identity byte
						if (rw_r)
						begin
							state_r <= ccg_pkg::ST_TX;
							tx_sr_r <= `CCG_ID_BYTE;
							id_r <= 1'b1;
						end
						else
							state_r <= ccg_pkg::ST_RX;
					end
				end
				ccg_pkg::ST_TX:
				begin
					if (rise)
						bit_cnt_r <= bit_cnt_r + 4'h1;
					else if (fall && bit_cnt_r == `CCG_BIT_LAST)
					begin
						bit_cnt_r <= 4'h0;
						state_r <= ccg_pkg::ST_RACK;
						if (!id_r)
							idx_r <= idx_r + 8'h01;
					end
					else if (fall)
						tx_sr_r <= {tx_sr_r[6:0], 1'b0};
				end
				ccg_pkg::ST_RACK:
				begin
					if (rise)
						mack_r <= !sda_s;
					else if (fall)
					begin
						// Not-acknowledge ends the read
						state_r <= mack_r ? ccg_pkg::ST_TX
							: ccg_pkg::ST_SKIP;
						tx_sr_r <= regs_r[idx_r];
						id_r <= 1'b0;
					end
				end
				default:
					state_r <= state_r;
			endcase
		end
	end

	// Copy request goes out only after the stop
	always_ff @(posedge sys_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			nv_start_r <= 1'b0;
			nv_restore_r <= 1'b0;
		end
		else
		begin
			nv_start_r <= nv_req;
			if (nv_req)
				nv_restore_r <= (cmd_r == `CCG_CMD_RESTORE);
		end
	end

	// Register file: restore stream or bus write
	always_ff @(posedge sys_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			for (int i = 0; i < `CCG_NREG; i++)
				regs_r[i] <= `CCG_REG_RESET;
		end
		else if (nv.wr)
			regs_r[nv.idx] <= nv.rdata;
		else if (wr_byte)
			regs_r[idx_r] <= rx_sr_r;
	end

	assign nv.start = nv_start_r;
	assign nv.restore = nv_restore_r;
	assign nv.wdata = regs_r[nv.idx];
	assign nv_busy_o = nv.busy;

	// Open drain: only ever pull low
	assign sda_o = 1'b0;
	assign sda_oe_o = ((state_r == ccg_pkg::ST_ACK) && ack_drv_r)
		|| ((state_r == ccg_pkg::ST_TX) && !tx_sr_r[7]);

	// Reserved select codes fall back to configuration zero
	wire sel_bad = (sel_s > `CCG_CFG_LAST);
	wire [2:0] cfg_idx = sel_bad ? `CCG_CFG_DEFAULT : sel_s;
	wire [7:0] cfg = regs_r[8'(`CCG_CFG_BASE + {5'h00, cfg_idx})];
	wire [1:0] mode = {cfg[`CCG_F_MODE_HI], cfg[`CCG_F_MODE_LO]};
	wire shut_mode = cfg[`CCG_F_SHUT];
	wire pol = regs_r[`CCG_POL_REG][`CCG_POL_BIT];
	wire [`CCG_NOUT-1:0] os = regs_r[`CCG_OS_REG][`CCG_NOUT-1:0];
	wire [`CCG_NOUT-1:0] oe = regs_r[`CCG_OE_REG][`CCG_NOUT-1:0];

	// Manual follows the pin; auto latches; revertive tracks loss
	logic on_sec_r;
	wire on_sec_nxt = !mode[1] ? sw_s :
		mode[0] ? lost_s : (on_sec_r || lost_s);

	// Enabling level of the pin follows polarity
	wire pin_act = pol ? sd_s : !sd_s;
	wire gshut = shut_mode && sd_s;
	logic [`CCG_NOUT-1:0] en_nxt;
	logic [`CCG_NOUT-1:0] hiz_nxt;
	logic [`CCG_NOUT-1:0] sus_nxt;

	// Per-output enable decode
	for (genvar n = 0; n < `CCG_NOUT; n++)
	begin : g_out
		// Mode zero suspends off the enabling level; mode one on polarity
		wire sus_pin = shut_mode ? pol : !pin_act;
		assign sus_nxt[n] = gshut || (os[n] && oe[n] && sus_pin);
		assign hiz_nxt[n] = !gshut && !os[n];
		assign en_nxt[n] = !gshut && os[n] && !sus_nxt[n];
	end

	// Registered pin-facing controls
	always_ff @(posedge sys_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			on_sec_r <= 1'b0;
			osc_bypass_sel_o <= 1'b0;
			ref_sel_o <= 1'b0;
			on_secondary_o <= 1'b0;
			cfg_invalid_o <= 1'b0;
			global_shutdown_o <= 1'b0;
			out_enable_o <= '0;
			out_hiz_o <= '0;
			out_suspend_o <= '0;
		end
		else
		begin
			on_sec_r <= on_sec_nxt;
			osc_bypass_sel_o <= cfg[`CCG_F_BYPASS];
			// Zero picks crystal input, one picks aux input
			ref_sel_o <= cfg[`CCG_F_PRIM] ^ on_sec_r;
			on_secondary_o <= on_sec_r;
			cfg_invalid_o <= sel_bad;
			global_shutdown_o <= gshut;
			out_enable_o <= en_nxt;
			out_hiz_o <= hiz_nxt;
			out_suspend_o <= sus_nxt;
		end
	end

	a_addr_ignore: assert property (
		@(posedge sys_clk_i) disable iff (reset_i)
		(rx_done && phase_r == `CCG_PH_ADDR && rx_sr_r[7:1] != `CCG_SLAVE_ADDR)
		|=> state_r == ccg_pkg::ST_SKIP && !sda_oe_o) else $error("stray ack");
	a_busy_nack: assert property (
		@(posedge sys_clk_i) disable iff (reset_i)
		(rx_done && phase_r == `CCG_PH_ADDR && nv.busy) |=> !sda_oe_o [*2])
		else $error("ack while busy");
	a_index_step: assert property (
		@(posedge sys_clk_i) disable iff (reset_i)
		wr_byte |=> idx_r == $past(idx_r) + 8'h01) else $error("no increment");
	a_save_go: assert property (
		@(posedge sys_clk_i) disable iff (reset_i)
		(nv_req && cmd_r == `CCG_CMD_SAVE) |=> ##1 nv.busy && !nv_restore_r)
		else $error("save not started");
	a_restore_go: assert property (
		@(posedge sys_clk_i) disable iff (reset_i)
		(nv_req && cmd_r == `CCG_CMD_RESTORE) |=> nv_start_r && nv_restore_r)
		else $error("restore not started");
	a_manual_src: assert property (
		@(posedge sys_clk_i) disable iff (reset_i)
		!mode[1] |=> on_sec_r == $past(sw_s)) else $error("manual source");
	a_auto_hold: assert property (
		@(posedge sys_clk_i) disable iff (reset_i)
		(mode == 2'h2 && on_sec_r) |=> on_sec_r) else $error("auto reverted");
	a_global_off: assert property (
		@(posedge sys_clk_i) disable iff (reset_i)
		(shut_mode && sd_s) |=> &out_suspend_o && out_enable_o == '0)
		else $error("no global shutdown");
	a_supply_hiz: assert property (
		@(posedge sys_clk_i) disable iff (reset_i)
		(!gshut && !os[0]) |=> out_hiz_o[0] && !out_enable_o[0])
		else $error("unpowered output driven");
	a_bad_select: assert property (
		@(posedge sys_clk_i) disable iff (reset_i)
		sel_bad |=> cfg_invalid_o) else $error("reserved select");
endmodule

//--- verilog/ccg_map.svh
// Behaviour
// - Answer only slave address 1101010, ignore others
// - Write frame: address, command 00, index, data
// - Register index increments after every data byte
// - Command low bits 01 saves registers to memory
// - Command low bits 10 restores registers from memory
// - Read returns identification byte, then register bytes
// - Operation starts after stop; no acknowledge meanwhile
// - Acknowledges resume once the operation completes
// - Power-up performs automatic restore without command
// - Commands accepted only after address is acknowledged
// - Select pins choose configuration zero to five
// - Bypass bit lets external clock replace crystal
// - Source bit and switch pin pick reference
// - Polarity bit at byte two sets pin level
// - Shutdown mode zero: pin suspends enabled outputs
// - Supply bit clear gives high impedance output unless global shutdown suspends it
// - Shutdown mode one: high pin suspends all
`ifndef CCG_MAP_SVH
`define CCG_MAP_SVH

// Bus identity
`define CCG_SLAVE_ADDR 7'h6A
// Identification byte; the value is arbitrary
`define CCG_ID_BYTE 8'h3C

// Command codes in the low two bits
`define CCG_CMD_WRITE 2'h0
`define CCG_CMD_SAVE 2'h1
`define CCG_CMD_RESTORE 2'h2

// Byte positions within a write frame
`define CCG_PH_ADDR 2'h0
`define CCG_PH_CMD 2'h1
`define CCG_PH_INDEX 2'h2
`define CCG_PH_DATA 2'h3
`define CCG_BIT_LAST 4'h8

// Register file
`define CCG_NREG 256
`define CCG_LAST_IDX 8'hFF
`define CCG_REG_RESET 8'h00
`define CCG_NV_BLANK 8'h00
`define CCG_POL_REG 8'h02
`define CCG_POL_BIT 0
`define CCG_OS_REG 8'h03
`define CCG_OE_REG 8'h04
`define CCG_CFG_BASE 8'h08
`define CCG_NOUT 7

// Fields of a configuration byte
`define CCG_F_BYPASS 0
`define CCG_F_PRIM 1
`define CCG_F_MODE_LO 2
`define CCG_F_MODE_HI 3
`define CCG_F_SHUT 4
`define CCG_CFG_LAST 3'h5
`define CCG_CFG_DEFAULT 3'h0

// Nonvolatile step time per byte
`define CCG_CLK_PERIOD_NS 10
`define CCG_NV_STEP_NS 40
`define CCG_NV_STEP_CYC (`CCG_NV_STEP_NS / `CCG_CLK_PERIOD_NS)

`endif

//--- verilog/ccg_pkg.sv
package ccg_pkg;
	// Serial engine states
	typedef enum logic [2:0]
	{
		ST_IDLE = 3'b000,
		ST_RX = 3'b001,
		ST_ACK = 3'b010,
		ST_TX = 3'b011,
		ST_RACK = 3'b100,
		ST_SKIP = 3'b101
	} ccg_i2c_st_t;
	// Memory copy states
	typedef enum logic
	{
		NV_IDLE = 1'b0,
		NV_RUN = 1'b1
	} ccg_nv_st_t;
endpackage

//--- verilog/ccg_nv_if.sv
`timescale 1ns/10ps
// Link between the register file and the nonvolatile store
interface ccg_nv_if;
	logic start;	// One-cycle request
	logic restore;	// Kind of request: 1 restore, 0 save
	logic busy;	// Copy running or pending
	logic [7:0] idx;	// Byte being copied
	logic wr;	// Restore write strobe
	logic [7:0] rdata;	// Stored byte toward registers
	logic [7:0] wdata;	// Register byte toward store
	modport ctl
	(
		output start, restore, wdata,
		input busy, idx, wr, rdata
	);
	modport mem
	(
		input start, restore, wdata,
		output busy, idx, wr, rdata
	);
endinterface

//--- verilog/ccg_nvmem.sv
`timescale 1ns/10ps
`include "ccg_map.svh"
module ccg_nvmem
(
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic reset_i,
	// Register file side
	ccg_nv_if.mem nv
);
	logic [7:0] store_r [`CCG_NREG];	// Nonvolatile image
	ccg_pkg::ccg_nv_st_t st_r;	// Copy state
	logic boot_r;	// Power-up restore pending
	logic rest_r;	// Current copy is a restore
	logic [7:0] idx_r;	// Byte index
	logic [3:0] div_r;	// Step divider
	wire step = (div_r == 4'(`CCG_NV_STEP_CYC - 1));
	wire run = (st_r == ccg_pkg::NV_RUN);

	// One byte per step; slow like a real cell write
	always_ff @(posedge sys_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			st_r <= ccg_pkg::NV_IDLE;
			boot_r <= 1'b1;
			rest_r <= 1'b0;
			idx_r <= 8'h00;
			div_r <= 4'h0;
		end
		else
		begin
			case (st_r)
				ccg_pkg::NV_IDLE:
				begin
					// Boot restore outranks a bus request
					if (boot_r || nv.start)
					begin
						st_r <= ccg_pkg::NV_RUN;
						rest_r <= boot_r || nv.restore;
					end
					boot_r <= 1'b0;
					idx_r <= 8'h00;
					div_r <= 4'h0;
				end
				default:
				begin
					div_r <= step ? 4'h0 : div_r + 4'h1;
					if (step)
					begin
						idx_r <= idx_r + 8'h01;
						// Last byte ends the copy
						if (idx_r == `CCG_LAST_IDX)
							st_r <= ccg_pkg::NV_IDLE;
					end
				end
			endcase
		end
	end

	// Save path writes the image
	always_ff @(posedge sys_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			for (int i = 0; i < `CCG_NREG; i++)
				store_r[i] <= `CCG_NV_BLANK;
		end
		else if (run && step && !rest_r)
			store_r[idx_r] <= nv.wdata;
	end

	// Busy from reset until the boot copy ends
	assign nv.busy = boot_r || run;
	assign nv.idx = idx_r;
	assign nv.wr = run && step && rest_r;
	assign nv.rdata = store_r[idx_r];

	a_boot_restore: assert property (
		@(posedge sys_clk_i) disable iff (reset_i)
		boot_r |=> run && rest_r && nv.busy) else $error("no boot restore");
	a_copy_ends: assert property (
		@(posedge sys_clk_i) disable iff (reset_i)
		(run && step && idx_r == `CCG_LAST_IDX) |=> !nv.busy)
		else $error("busy after last byte");
endmodule

//--- tb/ccg_i2c_master.sv
`timescale 1ns/10ps
// Bus master model; it changes pins only at falling clock edges
module ccg_i2c_master
(
	// Clock
	input wire logic sys_clk_i,
	// Wired data line
	input wire logic sda_line_i,
	// Drive, high means released to the pull-up
	output logic scl_o,
	output logic sda_o
);
	// Bus idle at time zero
	initial
	begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	// Wait n cycles, ending on a falling edge
	task automatic tick(input int n);
		repeat (n) @(negedge sys_clk_i);
	endtask
	// One bit: 8 cycles low, 8 high, well above the 4 needed
	task automatic bit_out(input logic b);
		sda_o = b;
		tick(4);
		scl_o = 1'b1;
		tick(8);
		scl_o = 1'b0;
		tick(4);
	endtask
	// Sample mid-high; the device changes data 3 cycles after a fall
	task automatic bit_in(output logic b);
		sda_o = 1'b1;
		tick(4);
		scl_o = 1'b1;
		tick(4);
		b = sda_line_i;
		tick(4);
		scl_o = 1'b0;
		tick(4);
	endtask
	task automatic start();
		sda_o = 1'b0;
		tick(8);
		scl_o = 1'b0;
		tick(4);
	endtask
	// Repeated start straight after an acknowledge
	task automatic rstart();
		sda_o = 1'b1;
		tick(4);
		scl_o = 1'b1;
		tick(8);
		start();
	endtask
	task automatic stop();
		sda_o = 1'b0;
		tick(4);
		scl_o = 1'b1;
		tick(8);
		sda_o = 1'b1;
		tick(8);
	endtask
	// Byte out MSB first, ack is 1 when the device pulled low
	task automatic wr_byte(input logic [7:0] d, output logic ack);
		logic b;
		for (int i = 7; i >= 0; i--)
			bit_out(d[i]);
		bit_in(b);
		ack = ~b;
	endtask
	// Byte in; the last byte of a read is answered with not-acknowledge
	task automatic rd_byte(output logic [7:0] d, input logic last);
		for (int i = 7; i >= 0; i--)
			bit_in(d[i]);
		bit_out(last);
	endtask
endmodule

//--- tb/test_clockgen_config_i2c_control.sv
`timescale 1ns/10ps
`include "ccg_map.svh"
// Self-checking bench for the configuration and control block
module test_clockgen_config_i2c_control;
	logic sys_clk = 1'b0;
	logic reset;
	logic [2:0] config_select;
	logic source_switch_pin;
	logic shutdown_oe_pin;
	logic prim_lost;
	wire logic scl, m_sda, sda_oe, sda_line, dev_sda;
	wire logic bypass, ref_sel, on_sec, cfg_inv, gshut, nv_busy;
	wire logic [6:0] o_en, o_hz, o_su;
	logic [7:0] wbuf [8];	// Data bytes of the next frame
	logic a;	// Last acknowledge seen
	int n_fail = 0;
	int compares = 0;
	// Pull-up wins unless a party drives its low value
	assign sda_line = m_sda & (~sda_oe | dev_sda);
	ccg_i2c_master m_u (.sys_clk_i(sys_clk), .sda_line_i(sda_line),
		.scl_o(scl), .sda_o(m_sda));
	ccg_ctrl dut_u (.sys_clk_i(sys_clk), .reset_i(reset), .scl_i(scl),
		.sda_i(sda_line), .sda_o(dev_sda), .sda_oe_o(sda_oe),
		.config_select_i(config_select),
		.source_switch_pin_i(source_switch_pin),
		.shutdown_oe_pin_i(shutdown_oe_pin), .prim_lost_i(prim_lost),
		.osc_bypass_sel_o(bypass), .ref_sel_o(ref_sel),
		.on_secondary_o(on_sec), .cfg_invalid_o(cfg_inv),
		.global_shutdown_o(gshut), .out_enable_o(o_en),
		.out_hiz_o(o_hz), .out_suspend_o(o_su), .nv_busy_o(nv_busy));
	// 100 MHz clock
	initial
	begin
		forever #5 sys_clk = ~sys_clk;
	end
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input string what, input logic [7:0] exp, got);
		compares++;
		if (got !== exp)
		begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Address byte alone; ack tells whether the device is ready
	task automatic probe(input logic [6:0] adr);
		m_u.start();
		m_u.wr_byte({adr, 1'b0}, a);
		m_u.stop();
		m_u.tick(8);
	endtask
	// Address, command 00 and index, each acknowledged
	task automatic head(input logic [7:0] idx);
		m_u.start();
		m_u.wr_byte({`CCG_SLAVE_ADDR, 1'b0}, a);
		chk("addr ack", 8'h01, {7'h0, a});
		m_u.wr_byte({6'h00, `CCG_CMD_WRITE}, a);
		chk("cmd ack", 8'h01, {7'h0, a});
		m_u.wr_byte(idx, a);
		chk("index ack", 8'h01, {7'h0, a});
	endtask
	task automatic wr_frame(input logic [7:0] idx, input int n);
		head(idx);
		for (int i = 0; i < n; i++)
		begin
			m_u.wr_byte(wbuf[i], a);
			chk("data ack", 8'h01, {7'h0, a});
		end
		m_u.stop();
		m_u.tick(8);
	endtask
	// Dataless index frame, repeated start, then read the identity byte and n bytes
	task automatic rd_check(input logic [7:0] idx, input int n);
		logic [7:0] d;
		head(idx);
		m_u.rstart();
		m_u.wr_byte({`CCG_SLAVE_ADDR, 1'b1}, a);
		m_u.rd_byte(d, 1'b0);
		chk("id byte", `CCG_ID_BYTE, d);
		for (int i = 0; i < n; i++)
		begin
			m_u.rd_byte(d, i == n - 1);
			chk("read byte", wbuf[i], d);
		end
		m_u.stop();
		m_u.tick(8);
	endtask
	// Two-byte save or restore frame; busy must wait for the stop
	task automatic cmd(input logic [1:0] code);
		m_u.start();
		m_u.wr_byte({`CCG_SLAVE_ADDR, 1'b0}, a);
		m_u.wr_byte({6'h00, code}, a);
		m_u.tick(4);
		chk("busy before stop", 8'h00, {7'h0, nv_busy});
		m_u.stop();
		m_u.tick(6);
		chk("busy after stop", 8'h01, {7'h0, nv_busy});
	endtask
	// Bounded wait for the copy to end; the bus stays idle meanwhile
	task automatic wait_idle();
		int i;
		for (i = 0; i < 3000 && nv_busy !== 1'b0; i++)
			m_u.tick(1);
		if (i == 3000)
		begin
			n_fail++;
			$display("ERROR nv_busy expected 0 seen %b", nv_busy);
			print_verdict();
		end
	endtask
	task automatic t_boot();
		probe(`CCG_SLAVE_ADDR);
		chk("ack while booting", 8'h00, {7'h0, a});
		for (int i = 0; i < 20 && a !== 1'b1; i++)
			probe(`CCG_SLAVE_ADDR);
		chk("ack after boot", 8'h01, {7'h0, a});
		probe(`CCG_SLAVE_ADDR ^ 7'h01);
		chk("foreign addr", 8'h00, {7'h0, a});
		wbuf = '{default: 8'h00};
		rd_check(`CCG_POL_REG, 3);
	endtask
	task automatic outs(input logic pin, input logic [6:0] en, hz, su,
		input logic gs);
		shutdown_oe_pin = pin;
		m_u.tick(8);
		chk("enable", {1'b0, en}, {1'b0, o_en});
		chk("hiz", {1'b0, hz}, {1'b0, o_hz});
		chk("suspend", {1'b0, su}, {1'b0, o_su});
		chk("shutdown", {7'h0, gs}, {7'h0, gshut});
	endtask
	task automatic t_outputs();
		wbuf[0] = 8'h01;
		wbuf[1] = 8'h7E;
		wbuf[2] = 8'h0F;
		wr_frame(`CCG_POL_REG, 3);
		rd_check(`CCG_POL_REG, 3);
		outs(1'b0, 7'h70, 7'h01, 7'h0E, 1'b0);
		outs(1'b1, 7'h7E, 7'h01, 7'h00, 1'b0);
		wbuf[0] = 8'h00;
		wr_frame(`CCG_POL_REG, 1);
		outs(1'b1, 7'h70, 7'h01, 7'h0E, 1'b0);
		outs(1'b0, 7'h7E, 7'h01, 7'h00, 1'b0);
		wbuf[0] = 8'h10;
		wr_frame(`CCG_CFG_BASE, 1);
		outs(1'b1, 7'h00, 7'h00, 7'h7F, 1'b1);
		outs(1'b0, 7'h7E, 7'h01, 7'h00, 1'b0);
		wbuf[0] = 8'h01;
		wr_frame(`CCG_POL_REG, 1);
		outs(1'b0, 7'h70, 7'h01, 7'h0E, 1'b0);
	endtask
	task automatic sw(input logic lost, exp);
		prim_lost = lost;
		m_u.tick(8);
		chk("on secondary", {7'h0, exp}, {7'h0, on_sec});
	endtask
	task automatic t_config();
		logic [1:0] c;
		for (int k = 0; k < 6; k++)
			wbuf[k] = k[7:0] & 8'h03;
		wr_frame(`CCG_CFG_BASE, 6);
		for (int s = 0; s < 16; s++)
		begin
			config_select = s[3:1];
			source_switch_pin = s[0];
			m_u.tick(8);
			c = (s < 12) ? s[2:1] : 2'h0;
			chk("bypass", {7'h0, c[0]}, {7'h0, bypass});
			chk("ref", {7'h0, c[1] ^ s[0]}, {7'h0, ref_sel});
			chk("manual", {7'h0, s[0]}, {7'h0, on_sec});
			chk("invalid", {7'h0, s >= 12}, {7'h0, cfg_inv});
		end
		config_select = 3'h0;
		source_switch_pin = 1'b0;
		wbuf[0] = 8'h08;
		wr_frame(`CCG_CFG_BASE, 1);
		sw(1'b1, 1'b1);
		sw(1'b0, 1'b1);
		wbuf[0] = 8'h0C;
		wr_frame(`CCG_CFG_BASE, 1);
		sw(1'b1, 1'b1);
		sw(1'b0, 1'b0);
	endtask
	task automatic t_nv();
		wbuf[0] = 8'hA5;
		wr_frame(8'h20, 1);
		cmd(`CCG_CMD_SAVE);
		probe(`CCG_SLAVE_ADDR);
		chk("ack during save", 8'h00, {7'h0, a});
		wait_idle();
		probe(`CCG_SLAVE_ADDR);
		chk("ack after save", 8'h01, {7'h0, a});
		wbuf[0] = 8'h5A;
		wr_frame(8'h20, 1);
		cmd(`CCG_CMD_RESTORE);
		wait_idle();
		wbuf[0] = 8'hA5;
		rd_check(8'h20, 1);
	endtask
	// Mid-run reset: enables clear, boot copy runs again, store is blank
	task automatic t_reset();
		reset = 1'b1;
		m_u.tick(2);
		chk("busy in reset", 8'h01, {7'h0, nv_busy});
		chk("enable in reset", 8'h00, {1'b0, o_en});
		reset = 1'b0;
		m_u.tick(2);
		chk("busy after reset", 8'h01, {7'h0, nv_busy});
		wait_idle();
		probe(`CCG_SLAVE_ADDR);
		chk("ack after reset", 8'h01, {7'h0, a});
		wbuf[0] = `CCG_NV_BLANK;
		rd_check(8'h20, 1);
	endtask
	// Main sequence: 6 cycles of reset, then the scenarios
	initial
	begin
		reset = 1'b1;
		config_select = 3'h0;
		source_switch_pin = 1'b0;
		shutdown_oe_pin = 1'b1;
		prim_lost = 1'b0;
		repeat (6) @(negedge sys_clk);
		reset = 1'b0;
		m_u.tick(4);
		t_boot();
		t_outputs();
		t_config();
		t_nv();
		t_reset();
		print_verdict();
	end
	// Cuts a hang short
	initial
	begin
		#1_000_000;
		n_fail++;
		$display("ERROR run time expected end seen hang");
		print_verdict();
	end
endmodule
